// [shsp_host_model.sv]
// Purpose: Host-side serial master model for the host serial slave port.
// Assumes: Mode 0, MSB first, 800 ns serial clock period.
// Notes: The serial clock stands low between frames.
module shsp_host_model (
  // Serial pins toward the port.
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 400;
  // Idle levels before the first frame.
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // One framed transfer of n whole bytes, first byte in tx[63:56].
  task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
    rx = '0;
    cs_n_o = 1'b0;
    #HALF;
    for (int i = 0; i < 8 * n; i++) begin
      mosi_o = tx[63 - i];
      #HALF;
      sck_o = 1'b1;
      rx[63 - i] = miso_i;
      #HALF;
      sck_o = 1'b0;
    end
    #HALF;
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // A released line must not look like held data.
    #(4 * HALF); // Leaves the port time to post its status.
  endtask
endmodule // shsp_host_model

// [shsp_pkg.sv]
// Purpose: Shared constants and types of the host serial slave port.
// Assumes: Register byte address is four times the register index.
// Notes: Command encoding and the interrupt registers are local choices.
package shsp_pkg;
  // Register indexes; byte address = index * 4.
  localparam logic [15:0] IDX_PROTECT = 16'h00b2;
  localparam logic [15:0] IDX_CMD = 16'h00fd;
  localparam logic [15:0] IDX_STAT = 16'h2708;
  localparam logic [15:0] IDX_CTRL = 16'h270c;
  localparam logic [15:0] IDX_IRQ_STAT = 16'h2710;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h2711;
  // Field positions.
  localparam int PROTECT_BIT = 6;
  localparam int CTRL_EN_BIT = 4;
  localparam int CTRL_SAFE_BIT = 3;
  // Reset values.
  localparam logic RST_EN = 1'h1;
  localparam logic RST_SAFE = 1'h0;
  localparam logic RST_PROTECT = 1'h0;
  // Command kind in command bits 7:6.
  localparam logic [1:0] OP_RAM_WR = 2'h0;
  localparam logic [1:0] OP_RAM_RD = 2'h1;
  localparam logic [1:0] OP_FLASH_RD = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  // Restricted write window size, flash page size and short command count.
  localparam logic [15:0] SAFE_LEN = 16'h0010;
  localparam int PAGE_SHIFT = 10;
  localparam logic [2:0] CNT_SHORT = 3'h7;
  // Interrupt bits.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_RDY_ERR = 1;
  localparam int IRQ_DROP = 2;
  localparam int IRQ_W = 3;
  typedef enum logic [1:0] {PH_CMD, PH_ADDR_HI, PH_ADDR_LO, PH_DATA} shsp_phase_t;
  typedef struct packed {
    logic rdy_err;
    logic rd_par;
    logic wr_par;
    logic [2:0] cnt;
    logic flash_mode;
    logic flash_rdy;
  } shsp_stat_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic flash;
    logic [15:0] addr;
    logic [7:0] wdata;
  } shsp_mem_req_t;
endpackage

// [shsp_port.sv]
// Purpose: Control and status logic of the host serial slave port.
// Assumes: Serial clock is far slower than the core clock; mode 0, MSB first.
// Notes: Shared memory answers a request in the same cycle via ready and data.
// How it works
// - Byte 0 of every host transaction is stored as the command, readable by the embedded cpu.
// - The port enable bit, set at reset, lets the serial pins act as the host interface.
// - With the guard set, host data writes outside the 16 byte window are dropped.
// - With flash protect set, host flash reads are refused and return zero.
// - With flash protect set, erasing page 0 or any page at or above the engine code base is blocked.
// - When chip select rises status bits 7:2 are rewritten and then hold until the next end; bits 1:0 are live.
// - Bit 7 reports that the memory was not ready for a read or write of the last command.
// - Bit 6 is the parity of all data bytes returned to the host.
// - Bit 5 is the parity of every byte the host sent, command and address included.
// - Bits 4:2 are the low bits of the data byte count, or all ones for one to three byte commands.
// - Bit 1 shows flash programming mode and is zero while the test strap is low.
// - Bit 0 shows the flash can take another write; the host waits for it.
//
// Strobed register access was decided locally.
module shsp_port #(
  parameter logic [15:0] SAFE_BASE = 16'h0000
) (
  // Clock and reset.
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  // Register port.
  input wire logic [15:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic IRQ_O,
  // Serial pins.
  input wire logic SERIAL_CLOCK_PIN_I,
  input wire logic CHIP_SELECT_PIN_N_I,
  input wire logic SERIAL_IN_PIN_I,
  output logic SERIAL_OUT_PIN_O,
  output logic SERIAL_OUT_PIN_OE_O,
  input wire logic TEST_STRAP_I,
  // Memory and flash side.
  output shsp_pkg::shsp_mem_req_t MEM_REQ_O,
  input wire logic MEM_READY_I,
  input wire logic [7:0] MEM_RDATA_I,
  input wire logic [5:0] ENGINE_CODE_BASE_I,
  input wire logic FLASH_PROG_MODE_I,
  input wire logic FLASH_READY_I,
  output logic FLASH_ERASE_O,
  output logic [5:0] FLASH_PAGE_O
);
  logic sck_s1_q, sck_s2_q, sck_prev_q, cs_s1_q, cs_s2_q, di_s1_q, di_s2_q, tst_s1_q, tst_s2_q;
  logic en_q, safe_q, protect_q, act_prev_q, fetch_q, wr_q, rd_q, flash_q, erase_q, err_q;
  localparam int IRQ_W = shsp_pkg::IRQ_W;
  logic wpar_q, rpar_q, pend_q;
  logic [2:0] bit_q;
  logic [6:0] sh_q;
  logic [7:0] tx_q, cmd_q, rdata_q, wdata_q;
  logic [15:0] addr_q, dcnt_q;
  logic [IRQ_W-1:0] irq_q, mask_q, irq_ev;
  shsp_pkg::shsp_phase_t ph_q;
  shsp_pkg::shsp_stat_t stat_q, stat_rd;
  logic act, cs_start, cs_end, rise, fall, byte_done, fmode, in_win, blocked;
  logic [7:0] rx_byte;
  logic [1:0] op;
  logic [5:0] page;

  // Pin inputs pass two flops before any logic looks at them.
  always_ff @(posedge CORE_CLK_I) begin
    sck_s1_q <= SERIAL_CLOCK_PIN_I;
    sck_s2_q <= sck_s1_q;
    cs_s1_q <= CHIP_SELECT_PIN_N_I;
    cs_s2_q <= cs_s1_q;
    di_s1_q <= SERIAL_IN_PIN_I;
    di_s2_q <= di_s1_q;
    tst_s1_q <= TEST_STRAP_I;
    tst_s2_q <= tst_s1_q;
  end

  // Edge and frame detection; a disabled port never sees a frame.
  assign act = ~cs_s2_q & en_q;
  assign cs_start = act & ~act_prev_q;
  assign cs_end = ~act & act_prev_q;
  assign rise = act & sck_s2_q & ~sck_prev_q;
  assign fall = act & ~sck_s2_q & sck_prev_q;
  assign byte_done = rise & (bit_q == 3'h7);
  assign rx_byte = {sh_q, di_s2_q};
  assign op = cmd_q[7:6];
  assign page = addr_q[15:shsp_pkg::PAGE_SHIFT];
  assign in_win = (addr_q >= SAFE_BASE) && (addr_q - SAFE_BASE < shsp_pkg::SAFE_LEN);
  assign blocked = protect_q & ((page == 6'h00) | (page >= ENGINE_CODE_BASE_I));
  assign fmode = tst_s2_q & FLASH_PROG_MODE_I;

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      sck_prev_q <= 1'b0;
      act_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s2_q;
      act_prev_q <= act;
    end
  end

  // Receive shifter, byte phase and data byte counter.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || cs_start) begin
      bit_q <= 3'h0;
      sh_q <= 7'h00;
      ph_q <= shsp_pkg::PH_CMD;
      dcnt_q <= 16'h0000;
    end else if (rise) begin
      bit_q <= bit_q + 3'h1;
      sh_q <= rx_byte[6:0];
      if (byte_done) begin
        if (ph_q == shsp_pkg::PH_DATA) begin
          dcnt_q <= dcnt_q + 16'h0001;
        end else begin
          ph_q <= shsp_pkg::shsp_phase_t'(ph_q + 2'h1);
        end
      end
    end
  end

  // Command capture; it stays until the next command arrives.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      cmd_q <= 8'h00;
    end else if (byte_done && ph_q == shsp_pkg::PH_CMD) begin
      cmd_q <= rx_byte;
    end
  end

  // Address load, memory requests and erase; address steps after each access.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      addr_q <= 16'h0000;
      fetch_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      flash_q <= 1'b0;
      erase_q <= 1'b0;
      wdata_q <= 8'h00;
    end else begin
      fetch_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      erase_q <= 1'b0;
      if (fetch_q || wr_q) begin
        addr_q <= addr_q + 16'h0001;
      end
      if (byte_done) begin
        unique case (ph_q)
          shsp_pkg::PH_CMD: flash_q <= (rx_byte[7:6] == shsp_pkg::OP_FLASH_RD);
          shsp_pkg::PH_ADDR_HI: addr_q[15:8] <= rx_byte;
          shsp_pkg::PH_ADDR_LO: addr_q[7:0] <= rx_byte;
          shsp_pkg::PH_DATA: begin
            wdata_q <= rx_byte;
            wr_q <= (op == shsp_pkg::OP_RAM_WR) & (~safe_q | in_win);
          end
        endcase
        if (ph_q != shsp_pkg::PH_CMD && ph_q != shsp_pkg::PH_ADDR_HI) begin
          fetch_q <= (op == shsp_pkg::OP_RAM_RD) | (op == shsp_pkg::OP_FLASH_RD);
          rd_q <= (op == shsp_pkg::OP_RAM_RD) | (op == shsp_pkg::OP_FLASH_RD & ~protect_q);
          erase_q <= (ph_q == shsp_pkg::PH_ADDR_LO) & (op == shsp_pkg::OP_ERASE);
        end
      end
    end
  end

  assign MEM_REQ_O.wr = wr_q;
  assign MEM_REQ_O.rd = rd_q;
  assign MEM_REQ_O.flash = flash_q;
  assign MEM_REQ_O.addr = addr_q;
  assign MEM_REQ_O.wdata = wdata_q;
  assign FLASH_ERASE_O = erase_q & ~blocked;
  assign FLASH_PAGE_O = page;

  // Transmit shifter; no shift on the fall right after a byte so the MSB survives.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || cs_start) begin
      tx_q <= 8'h00;
    end else if (fetch_q) begin
      tx_q <= (rd_q && MEM_READY_I) ? MEM_RDATA_I : 8'h00;
    end else if (fall && bit_q != 3'h0) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  assign SERIAL_OUT_PIN_O = tx_q[7];
  assign SERIAL_OUT_PIN_OE_O = act;

  // Per-transaction accumulators, cleared at the start of every frame.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || cs_start) begin
      wpar_q <= 1'b0;
      rpar_q <= 1'b0;
      pend_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      if (byte_done) begin
        wpar_q <= wpar_q ^ (^rx_byte);
      end
      if (fetch_q) begin
        pend_q <= (rd_q && MEM_READY_I) ? ^MEM_RDATA_I : 1'b0;
      end
      // Parity is taken as a byte leaves, since the byte fetched after the last one is never sent.
      if (byte_done && ph_q == shsp_pkg::PH_DATA) begin
        rpar_q <= rpar_q ^ pend_q;
      end
      if ((wr_q || rd_q) && !MEM_READY_I) begin
        err_q <= 1'b1;
      end
    end
  end

  // Status byte: written once per frame end, otherwise held.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      stat_q <= '0;
    end else if (cs_end) begin
      stat_q.rdy_err <= err_q;
      stat_q.rd_par <= rpar_q;
      stat_q.wr_par <= wpar_q;
      stat_q.cnt <= (dcnt_q == 16'h0000) ? shsp_pkg::CNT_SHORT : dcnt_q[2:0];
    end
  end

  // Flash mode bits are live so the host can poll readiness between writes.
  always_comb begin
    stat_rd = stat_q;
    stat_rd.flash_mode = fmode;
    stat_rd.flash_rdy = fmode & FLASH_READY_I;
  end

  // Sticky interrupt sources; a new event beats a same-cycle clear.
  always_comb begin
    irq_ev = '0;
    irq_ev[shsp_pkg::IRQ_DONE] = cs_end;
    irq_ev[shsp_pkg::IRQ_RDY_ERR] = (wr_q || rd_q) && !MEM_READY_I;
    irq_ev[shsp_pkg::IRQ_DROP] = (rd_q != fetch_q) || (erase_q && blocked);
  end

  // Software registers; writes to read-only words are ignored.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      en_q <= shsp_pkg::RST_EN;
      safe_q <= shsp_pkg::RST_SAFE;
      protect_q <= shsp_pkg::RST_PROTECT;
      mask_q <= '0;
      irq_q <= '0;
    end else begin
      if (REG_WR_I && REG_ADDR_I == {shsp_pkg::IDX_CTRL[13:0], 2'h0}) begin
        en_q <= REG_WDATA_I[shsp_pkg::CTRL_EN_BIT];
        safe_q <= REG_WDATA_I[shsp_pkg::CTRL_SAFE_BIT];
      end
      if (REG_WR_I && REG_ADDR_I == {shsp_pkg::IDX_PROTECT[13:0], 2'h0}) begin
        protect_q <= REG_WDATA_I[shsp_pkg::PROTECT_BIT];
      end
      if (REG_WR_I && REG_ADDR_I == {shsp_pkg::IDX_IRQ_MASK[13:0], 2'h0}) begin
        mask_q <= REG_WDATA_I[IRQ_W-1:0];
      end
      if (REG_WR_I && REG_ADDR_I == {shsp_pkg::IDX_IRQ_STAT[13:0], 2'h0}) begin
        irq_q <= (irq_q & ~REG_WDATA_I[IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_q <= irq_q | irq_ev;
      end
    end
  end

  assign IRQ_O = |(irq_q & mask_q);

  // Read data one cycle after the strobe; unmapped words read zero.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      rdata_q <= 8'h00;
    end else if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        {shsp_pkg::IDX_CMD[13:0], 2'h0}: rdata_q <= cmd_q;
        {shsp_pkg::IDX_STAT[13:0], 2'h0}: rdata_q <= stat_rd;
        {shsp_pkg::IDX_CTRL[13:0], 2'h0}: rdata_q <= 8'(({7'h00, en_q} << shsp_pkg::CTRL_EN_BIT)
          | ({7'h00, safe_q} << shsp_pkg::CTRL_SAFE_BIT));
        {shsp_pkg::IDX_PROTECT[13:0], 2'h0}: rdata_q <= 8'({7'h00, protect_q} << shsp_pkg::PROTECT_BIT);
        {shsp_pkg::IDX_IRQ_STAT[13:0], 2'h0}: rdata_q <= 8'(irq_q);
        {shsp_pkg::IDX_IRQ_MASK[13:0], 2'h0}: rdata_q <= 8'(mask_q);
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign REG_RDATA_O = rdata_q;

  // Checks of the port behaviour.
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_frame_end;
    cs_end;
  endsequence
  sequence s_err_end;
    s_frame_end ##0 err_q;
  endsequence
  chk_cmd_capture: assert property (byte_done && ph_q == shsp_pkg::PH_CMD |=> cmd_q == $past(rx_byte))
    else $error("Command byte not captured.");
  chk_port_off: assert property (!en_q |-> !SERIAL_OUT_PIN_OE_O && !cs_start)
    else $error("Disabled port is active.");
  chk_guard_write: assert property (MEM_REQ_O.wr |-> !safe_q || in_win)
    else $error("Guarded write left the window.");
  chk_flash_refuse: assert property (MEM_REQ_O.rd && MEM_REQ_O.flash |-> !$past(protect_q))
    else $error("Protected flash read issued.");
  chk_erase_block: assert property (FLASH_ERASE_O |-> !protect_q || (page != 6'h00 && page < ENGINE_CODE_BASE_I))
    else $error("Protected page erased.");
  chk_stat_hold: assert property (!cs_end |=> $stable(stat_q))
    else $error("Status changed outside frame end.");
  chk_rdy_error: assert property (s_err_end |=> stat_q.rdy_err ##1 stat_q.rdy_err || $past(cs_end))
    else $error("Ready error not reported.");
  chk_wpar_end: assert property (s_frame_end |=> stat_q.wr_par == $past(wpar_q))
    else $error("Write parity wrong.");
  chk_rpar_end: assert property (s_frame_end |=> stat_q.rd_par == $past(rpar_q))
    else $error("Read parity wrong.");
  chk_cnt_short: assert property (s_frame_end ##0 dcnt_q == 16'h0000 |=> stat_q.cnt == shsp_pkg::CNT_SHORT)
    else $error("Short command count wrong.");
  chk_fmode_strap: assert property (!tst_s2_q |-> !stat_rd.flash_mode && !stat_rd.flash_rdy)
    else $error("Flash mode without strap.");
  chk_par_clear: assert property (cs_start |=> !wpar_q && !rpar_q && !err_q)
    else $error("Accumulators not cleared.");
endmodule // shsp_port

// [shsp_port_bench.sv]
// Purpose: Self-checking bench of the host serial slave port.
// Assumes: Window base 0x0010, engine code base page 0x10.
// Notes: Memory answers at once with the low address byte xor 0x5a.
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t got %h want %h", $time, (g), (e)); end end
module shsp_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] A_PROT = shsp_pkg::IDX_PROTECT << 2;
  localparam logic [15:0] A_CMD = shsp_pkg::IDX_CMD << 2;
  localparam logic [15:0] A_STAT = shsp_pkg::IDX_STAT << 2;
  localparam logic [15:0] A_CTRL = shsp_pkg::IDX_CTRL << 2;
  localparam logic [15:0] A_IRQ = shsp_pkg::IDX_IRQ_STAT << 2;
  localparam logic [15:0] A_MASK = shsp_pkg::IDX_IRQ_MASK << 2;
  logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, rdy = 1'b1, strap = 1'b0, fmode = 1'b0, frdy = 1'b0;
  logic [15:0] addr = '0, last_a;
  logic [7:0] wdat = '0, rdat, d, last_d, mem_q;
  logic [5:0] ecb = 6'h10, page, last_pg;
  logic irq, so, oe, miso, sck, cs_n, mosi, erase;
  logic [63:0] rx;
  shsp_pkg::shsp_mem_req_t req;
  int error_cnt = 0, num_checks = 0, wr_n = 0, rd_n = 0, er_n = 0, oe_n = 0, n0;
  // Free-running core clock.
  always #50 clk = ~clk;
  // The line shows the inverse when undriven, so a stale bit never passes.
  assign miso = oe ? so : ~so;
  assign mem_q = req.addr[7:0] ^ 8'h5a;
  shsp_port #(.SAFE_BASE(16'h0010)) shsp_port_inst (.CORE_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdat), .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdat), .IRQ_O(irq),
    .SERIAL_CLOCK_PIN_I(sck), .CHIP_SELECT_PIN_N_I(cs_n), .SERIAL_IN_PIN_I(mosi), .SERIAL_OUT_PIN_O(so),
    .SERIAL_OUT_PIN_OE_O(oe), .TEST_STRAP_I(strap), .MEM_REQ_O(req), .MEM_READY_I(rdy), .MEM_RDATA_I(mem_q),
    .ENGINE_CODE_BASE_I(ecb), .FLASH_PROG_MODE_I(fmode), .FLASH_READY_I(frdy), .FLASH_ERASE_O(erase),
    .FLASH_PAGE_O(page));
  shsp_host_model shsp_host_model_inst (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
  // Count memory pulses, erase pulses and driven cycles of the output pin.
  always @(posedge clk) begin
    if (req.wr) begin
      wr_n++;
      last_a = req.addr;
      last_d = req.wdata;
    end
    if (req.rd) rd_n++;
    if (erase) begin
      er_n++;
      last_pg = page;
    end
    if (oe) oe_n++;
  end
  task rreg(input logic [15:0] a, output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #10 q = rdat;
  endtask
  task wreg(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdat <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task expr(input logic [15:0] a, input logic [7:0] e);
    rreg(a, d);
    `CHK(d, e)
  endtask
  task fr(input int n, input logic [63:0] tx);
    shsp_host_model_inst.frame(n, tx, rx);
  endtask
  function automatic logic [7:0] st(input logic e, input logic rp, input logic wp, input logic [2:0] c);
    return {e, rp, wp, c, 2'b00};
  endfunction
  task t_reset;
    expr(A_CTRL, 8'h10);
    expr(A_PROT, 8'h00);
    wreg(A_STAT, 8'hff);
    expr(A_STAT, 8'h00);
    expr(16'h0100, 8'h00);
  endtask
  task t_write;
    n0 = wr_n;
    wreg(A_MASK, 8'h07);
    fr(5, {8'h2d, 8'h00, 8'h12, 8'ha5, 8'h3c, 24'h0});
    `CHK(wr_n - n0, 2)
    `CHK({last_a, last_d}, {16'h0013, 8'h3c})
    expr(A_CMD, 8'h2d);
    expr(A_STAT, st(0, 0, ^{8'h2d, 8'h12, 8'ha5, 8'h3c}, 3'h2));
    `CHK(irq, 1'b1)
    wreg(A_IRQ, 8'hff);
    // The clear lands at the edge that ends the write, so look after it has settled.
    #10;
    `CHK(irq, 1'b0)
    wreg(A_MASK, 8'h00);
    fr(1, {8'h6c, 56'h0});
    `CHK(irq, 1'b0)
    expr(A_STAT, st(0, 0, ^8'h6c, 3'h7));
    expr(A_IRQ, 8'h01);
    wreg(A_IRQ, 8'hff);
  endtask
  task t_read;
    n0 = rd_n;
    fr(6, {8'h41, 8'h00, 8'h20, 40'h0});
    `CHK(rd_n - n0, 4)
    `CHK(rx[39:16], {8'h20, 8'h21, 8'h22} ^ {3{8'h5a}})
    expr(A_STAT, st(0, ^({8'h20, 8'h21, 8'h22} ^ {3{8'h5a}}), ^{8'h41, 8'h20}, 3'h3));
    @(posedge clk);
    rdy <= 1'b0;
    fr(4, {8'h41, 8'h00, 8'h20, 40'h0});
    `CHK(rx[39:32], 8'h00)
    expr(A_STAT, st(1, 0, ^{8'h41, 8'h20}, 3'h1));
    rdy <= 1'b1;
    expr(A_IRQ, 8'h03);
    wreg(A_IRQ, 8'hff);
  endtask
  task t_guard;
    n0 = wr_n;
    wreg(A_CTRL, 8'h18);
    fr(5, {8'h00, 8'h00, 8'h1f, 8'h11, 8'h22, 24'h0});
    `CHK({last_a, last_d}, {16'h001f, 8'h11})
    fr(4, {8'h00, 8'h00, 8'h0f, 8'h33, 32'h0});
    `CHK(wr_n - n0, 1)
    expr(A_IRQ, 8'h01);
    wreg(A_IRQ, 8'hff);
    wreg(A_CTRL, 8'h10);
  endtask
  task t_prot;
    logic [5:0] tbl [5];
    int b;
    tbl = '{6'h00, 6'h05, 6'h0f, 6'h10, 6'h3f};
    wreg(A_PROT, 8'h40);
    n0 = rd_n;
    fr(4, {8'h80, 8'h00, 8'h20, 40'h0});
    `CHK(rd_n - n0, 0)
    `CHK(rx[39:32], 8'h00)
    expr(A_IRQ, 8'h05);
    wreg(A_IRQ, 8'hff);
    for (int i = 0; i < 5; i++) begin
      b = er_n;
      fr(3, {8'hc0, tbl[i], 2'b00, 8'h00, 40'h0});
      `CHK(er_n - b, int'(tbl[i] != 6'h00 && tbl[i] < ecb))
    end
    expr(A_STAT, st(0, 0, ^{8'hc0, 6'h3f}, 3'h7));
    wreg(A_PROT, 8'h00);
    fr(3, {8'hc0, 56'h0});
    `CHK({er_n - b, last_pg}, {32'sd1, 6'h00})
    fr(4, {8'h80, 8'h00, 8'h20, 40'h0});
    `CHK(rx[39:32], 8'h7a)
  endtask
  task t_off;
    wreg(A_CTRL, 8'h00);
    n0 = oe_n;
    fr(4, {8'h7e, 56'h0});
    `CHK(oe_n - n0, 0)
    expr(A_CMD, 8'h80);
    wreg(A_CTRL, 8'h10);
  endtask
  task t_flash;
    @(posedge clk);
    fmode <= 1'b1;
    frdy <= 1'b1;
    repeat (6) @(posedge clk);
    rreg(A_STAT, d);
    `CHK(d[1], 1'b0)
    strap <= 1'b1;
    repeat (6) @(posedge clk);
    rreg(A_STAT, d);
    `CHK(d[1:0], 2'b11)
    frdy <= 1'b0;
    repeat (6) @(posedge clk);
    rreg(A_STAT, d);
    `CHK(d[1:0], 2'b10)
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence after an eight-cycle reset.
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset;
    t_write;
    t_read;
    t_guard;
    t_prot;
    t_off;
    t_flash;
    tally_and_finish;
  end
  // Watchdog well beyond the roughly 0.4 millisecond the tests need.
  initial begin
    #3000000;
    error_cnt++;
    tally_and_finish;
  end
endmodule // shsp_port_bench
